//--- shared/grz_defines.vh
// constants of the gain, core reset and sampling zone register bank
// assumes inclusion by bare name from every design file of the block
//
// What this block does
// - 4-bit gain code scales samples before down-converter, 0 to 11 dB
// - core reset bit pulsed high-low resets both channels' digital core
// - zone settings stay pending until the core reset pulse completes
// - zone enable bit 3 gates explicit operating zone specification
// - 3-bit zone select goes to correction loop, 000..011 zones one-four
// - main page per channel 680000h/680001h, reset at 000h, zone 0A2h
`ifndef GRZ_DEFINES_VH
`define GRZ_DEFINES_VH

// ----------------------------------------------------------------
// page addresses
// ----------------------------------------------------------------
`define GRZ_PAGE_GAIN_A 24'h610005
`define GRZ_PAGE_GAIN_B 24'h610105
`define GRZ_PAGE_MAIN_A 24'h680000
`define GRZ_PAGE_MAIN_B 24'h680001
`define GRZ_PAGE_RESET 24'h000000

// ----------------------------------------------------------------
// register indexes, byte address is four times the index
// ----------------------------------------------------------------
`define GRZ_IDX_CORE_RESET 8'h00
`define GRZ_IDX_ZONE 8'ha2
`define GRZ_IDX_GAIN 8'ha6
`define GRZ_IDX_STATUS 8'hfe
`define GRZ_IDX_PAGE 8'hff

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define GRZ_RST_BIT 0
`define GRZ_ZONE_EN_BIT 3
`define GRZ_ZONE_SEL_LSB 0
`define GRZ_ZONE_SEL_MSB 2
`define GRZ_GAIN_LSB 0
`define GRZ_GAIN_MSB 3
`define GRZ_ST_CORE_RST 0
`define GRZ_ST_EN_A 1
`define GRZ_ST_SEL_A_LSB 2
`define GRZ_ST_EN_B 5
`define GRZ_ST_SEL_B_LSB 6

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define GRZ_RST_RESET 1'b0
`define GRZ_ZONE_EN_RESET 1'b0
`define GRZ_ZONE_SEL_RESET 3'h0
`define GRZ_GAIN_RESET 4'h0
`define GRZ_GAIN_MAX 4'hb
`define GRZ_ZONE_RSVD_BIT 2
`define GRZ_GAIN_FRAC 10

`endif

//--- hdl/grz_gain.v
// digital gain stage for one channel ahead of the down-converter
// assumes signed 14-bit samples, one per clock, and a core reset level
`timescale 1ns/1ps
`include "grz_defines.vh"

module grz_gain (
  // clock and reset
  input wire clk,
  input wire resetn,
  // control
  input wire core_clr,
  input wire [3:0] gain_code,
  // samples
  input wire [13:0] sample_in,
  output reg [13:0] sample_out
);

  // ----------------------------------------------------------------
  // gain table, linear factors with ten fraction bits
  // ----------------------------------------------------------------
  function [11:0] gain_factor;
    input [3:0] code;
    begin
      case (code)
        4'h0: gain_factor = 12'h400;
        4'h1: gain_factor = 12'h47d;
        4'h2: gain_factor = 12'h509;
        4'h3: gain_factor = 12'h5a6;
        4'h4: gain_factor = 12'h657;
        4'h5: gain_factor = 12'h71d;
        4'h6: gain_factor = 12'h7fb;
        4'h7: gain_factor = 12'h8f4;
        4'h8: gain_factor = 12'ha0c;
        4'h9: gain_factor = 12'hb46;
        4'ha: gain_factor = 12'hca6;
        4'hb: gain_factor = 12'he31;
        default: gain_factor = 12'h400; // unused codes fall back to unity
      endcase
    end
  endfunction

  wire [11:0] factor;
  wire signed [26:0] product;
  wire signed [26:0] scaled;
  wire fits;

  assign factor = gain_factor(gain_code);
  assign product = $signed(sample_in) * $signed({1'b0, factor});
  assign scaled = product >>> `GRZ_GAIN_FRAC;
  assign fits = (scaled[26:13] == {14{scaled[26]}});

  // saturating output register, cleared by the core reset
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_out <= 14'h0000;
    end else if (core_clr) begin
      sample_out <= 14'h0000;
    end else if (fits) begin
      sample_out <= scaled[13:0];
    end else begin
      sample_out <= scaled[26] ? 14'h2000 : 14'h1fff;
    end
  end

endmodule

//--- hdl/grz_top.v
// gain, core reset and sampling zone register bank of two channels
// assumes a single AHB-Lite master and samples synchronous to clk
`timescale 1ns/1ps
`include "grz_defines.vh"

module grz_top (
  // clock and reset
  input wire clk,
  input wire resetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // sample path
  input wire [13:0] chan_a_sample_in,
  input wire [13:0] chan_b_sample_in,
  output wire [13:0] chan_a_sample_out,
  output wire [13:0] chan_b_sample_out,
  // digital core control
  output wire core_reset_out,
  // analog correction loop
  output wire chan_a_zone_en,
  output wire [2:0] chan_a_zone_sel,
  output wire chan_b_zone_en,
  output wire [2:0] chan_b_zone_sel
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // main digital page of a channel
  function [23:0] main_page;
    input ch;
    begin
      main_page = ch ? `GRZ_PAGE_MAIN_B : `GRZ_PAGE_MAIN_A;
    end
  endfunction

  // digital gain page of a channel
  function [23:0] gain_page;
    input ch;
    begin
      gain_page = ch ? `GRZ_PAGE_GAIN_B : `GRZ_PAGE_GAIN_A;
    end
  endfunction

  // register hit on a given page and index
  function reg_hit;
    input [23:0] cur_page;
    input [23:0] want_page;
    input [7:0] cur_idx;
    input [7:0] want_idx;
    begin
      reg_hit = (cur_page == want_page) && (cur_idx == want_idx);
    end
  endfunction

  // ----------------------------------------------------------------
  // bus pipeline
  // ----------------------------------------------------------------
  reg dp_wr_r;
  reg dp_rd_r;
  reg dp_ok_r;
  reg [7:0] dp_idx_r;
  reg rd_wait_r;
  reg rd_wait_nxt;
  reg [23:0] page_r;
  reg [31:0] rd_val;
  wire addr_ok;
  wire wr_en;
  wire [1:0] ch_rst_bit;
  wire [15:0] ch_rd_val;
  wire [1:0] ch_act_en;
  wire [5:0] ch_act_sel;
  wire [7:0] ch_gain;
  wire [31:0] status_val;
  reg any_rst_q_r;
  wire any_rst;
  wire pulse_done;

  // address phase taken when selected, ready and nonseq or seq
  wire addr_phase;
  assign addr_phase = hsel && hready && htrans[1];
  assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);

  // reads take one wait state so a preceding write is visible
  // hrdata is loaded in that wait cycle from settled registers
  assign hreadyout = !(dp_rd_r && !rd_wait_r);
  assign hresp = 1'b0;

  // write commits at the end of its data phase
  assign wr_en = dp_wr_r && dp_ok_r && hreadyout;

  // wait-state sequencing of a read data phase
  always @* begin
    rd_wait_nxt = rd_wait_r;
    if (addr_phase) begin
      rd_wait_nxt = 1'b0;
    end else if (dp_rd_r && !rd_wait_r) begin
      rd_wait_nxt = 1'b1;
    end
  end

  // address phase capture
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dp_wr_r <= 1'b0;
      dp_rd_r <= 1'b0;
      dp_ok_r <= 1'b0;
      dp_idx_r <= 8'h00;
      rd_wait_r <= 1'b0;
    end else begin
      rd_wait_r <= rd_wait_nxt;
      if (hready) begin
        dp_wr_r <= addr_phase && hwrite;
        dp_rd_r <= addr_phase && !hwrite;
        dp_ok_r <= addr_phase && addr_ok;
        dp_idx_r <= haddr[9:2];
      end
    end
  end

  // page select register, steers which channel page is reached
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      page_r <= `GRZ_PAGE_RESET;
    end else if (wr_en && (dp_idx_r == `GRZ_IDX_PAGE)) begin
      page_r <= hwdata[23:0];
    end
  end

  // ----------------------------------------------------------------
  // global core reset
  // ----------------------------------------------------------------

  assign any_rst = |ch_rst_bit;
  assign core_reset_out = any_rst;

  // completion of high-low pulse
  // bits are ored, so a pulse ends only once neither bit is set
  assign pulse_done = any_rst_q_r && !any_rst;

  // previous level of the reset bit for the falling edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      any_rst_q_r <= 1'b0;
    end else begin
      any_rst_q_r <= any_rst;
    end
  end

  // ----------------------------------------------------------------
  // per-channel registers
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_chan
      reg rst_bit_r;
      reg zone_en_r;
      reg [2:0] zone_sel_r;
      reg [3:0] gain_r;
      reg act_en_r;
      reg [2:0] act_sel_r;
      wire hit_rst;
      wire hit_zone;
      wire hit_gain;

      assign hit_rst = reg_hit(page_r, main_page(c == 1), dp_idx_r,
                               `GRZ_IDX_CORE_RESET);
      assign hit_zone = reg_hit(page_r, main_page(c == 1), dp_idx_r,
                                `GRZ_IDX_ZONE);
      assign hit_gain = reg_hit(page_r, gain_page(c == 1), dp_idx_r,
                                `GRZ_IDX_GAIN);

      // software-written fields of this channel
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          rst_bit_r <= `GRZ_RST_RESET;
          zone_en_r <= `GRZ_ZONE_EN_RESET;
          zone_sel_r <= `GRZ_ZONE_SEL_RESET;
          gain_r <= `GRZ_GAIN_RESET;
        end else if (wr_en) begin
          if (hit_rst) begin
            rst_bit_r <= hwdata[`GRZ_RST_BIT];
          end
          if (hit_zone) begin
            zone_en_r <= hwdata[`GRZ_ZONE_EN_BIT];
            zone_sel_r <= hwdata[`GRZ_ZONE_SEL_MSB:`GRZ_ZONE_SEL_LSB];
          end
          if (hit_gain) begin
            gain_r <= hwdata[`GRZ_GAIN_MSB:`GRZ_GAIN_LSB];
          end
        end
      end

      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          act_en_r <= `GRZ_ZONE_EN_RESET;
          act_sel_r <= `GRZ_ZONE_SEL_RESET;
        end else if (pulse_done) begin
          act_en_r <= zone_en_r;
          if (!zone_sel_r[`GRZ_ZONE_RSVD_BIT]) begin
            act_sel_r <= zone_sel_r;
          end
        end
      end

      // read-back of this channel's registers on its own pages
      assign ch_rd_val[c*8 +: 8] =
        hit_rst ? {7'h00, rst_bit_r} :
        hit_zone ? {4'h0, zone_en_r, zone_sel_r} :
        hit_gain ? {4'h0, gain_r} : 8'h00;

      assign ch_rst_bit[c] = rst_bit_r;
      assign ch_act_en[c] = act_en_r;
      assign ch_act_sel[c*3 +: 3] = act_sel_r;
      assign ch_gain[c*4 +: 4] = gain_r;
    end
  endgenerate

  // ----------------------------------------------------------------
  // gain stages
  // ----------------------------------------------------------------

  grz_gain u_gain_a (
    .clk(clk),
    .resetn(resetn),
    .core_clr(any_rst),
    .gain_code(ch_gain[3:0]),
    .sample_in(chan_a_sample_in),
    .sample_out(chan_a_sample_out)
  );

  grz_gain u_gain_b (
    .clk(clk),
    .resetn(resetn),
    .core_clr(any_rst),
    .gain_code(ch_gain[7:4]),
    .sample_in(chan_b_sample_in),
    .sample_out(chan_b_sample_out)
  );

  // ----------------------------------------------------------------
  // zone outputs to the correction loop
  // ----------------------------------------------------------------

  assign chan_a_zone_en = ch_act_en[0];
  assign chan_b_zone_en = ch_act_en[1];
  assign chan_a_zone_sel = ch_act_sel[2:0];
  assign chan_b_zone_sel = ch_act_sel[5:3];

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------

  // status word of reset level and active zones, reachable on any page
  assign status_val = {23'h000000,
                       ch_act_sel[5:3], ch_act_en[1],
                       ch_act_sel[2:0], ch_act_en[0],
                       any_rst};

  // read multiplexer, unmapped addresses read as zero
  always @* begin
    rd_val = 32'h00000000;
    if (dp_ok_r) begin
      case (dp_idx_r)
        `GRZ_IDX_PAGE: rd_val = {8'h00, page_r};
        `GRZ_IDX_STATUS: rd_val = status_val;
        default: rd_val = {24'h000000, ch_rd_val[15:8] | ch_rd_val[7:0]};
      endcase
    end
  end

  // read data register, loaded in the wait cycle of a read
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else if (dp_rd_r && !rd_wait_r) begin
      hrdata <= rd_val;
    end
  end

endmodule

//--- testbench/grz_top_asserts.sv
// port checker of the gain and zone register bank
// assumes a bind into grz_top and a single clock domain
`timescale 1ns/1ps

module grz_top_asserts (
  // clock and reset
  input wire clk,
  input wire resetn,
  // bus
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  // outputs
  input wire [13:0] chan_a_sample_out,
  input wire [13:0] chan_b_sample_out,
  input wire core_reset_out,
  input wire chan_a_zone_en,
  input wire [2:0] chan_a_zone_sel,
  input wire chan_b_zone_en,
  input wire [2:0] chan_b_zone_sel
);
  // ----
  // accepted transfers
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire rd_req = hsel && hready && htrans[1] && !hwrite;
  wire wr_req = hsel && hready && htrans[1] && hwrite;
  // core reset level one and two edges back
  logic rst_d1;
  logic rst_d2;

  always @(posedge clk) begin
    rst_d1 <= core_reset_out;
    rst_d2 <= rst_d1;
  end

  chk_okay_resp: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_read_wait: assert property (rd_req |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (wr_req |=> hreadyout)
    else $error("write data phase stalled");
  chk_wait_cause: assert property (!hreadyout |-> $past(rd_req))
    else $error("stall without read");
  chk_zone_a_hold: assert property (
    $changed({chan_a_zone_en, chan_a_zone_sel}) |-> rst_d2 && !rst_d1)
    else $error("zone a changed without reset pulse");
  chk_zone_b_hold: assert property (
    $changed({chan_b_zone_en, chan_b_zone_sel}) |-> rst_d2 && !rst_d1)
    else $error("zone b changed without reset pulse");
  chk_rsvd_zone: assert property (
    !chan_a_zone_sel[2] && !chan_b_zone_sel[2])
    else $error("reserved zone became active");
  chk_core_clear: assert property (rst_d1 && core_reset_out
    |-> chan_a_sample_out == 14'h0 && chan_b_sample_out == 14'h0)
    else $error("samples pass during core reset");

  cover property (rd_req);
  cover property ($fell(core_reset_out));
  cover property (chan_b_zone_en && chan_b_zone_sel == 3'h3);
endmodule

//--- testbench/test_grz_top.sv
// self-checking bench of the gain and zone register bank
// assumes grz_top with one bus master and free running samples
`timescale 1ns/1ps
`include "grz_defines.vh"

module test_grz_top;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [13:0] in_a = 14'h0;
  reg [13:0] in_b = 14'h0;
  wire hreadyout, hresp, core_rst, en_a, en_b;
  wire [31:0] hrdata;
  wire [13:0] out_a, out_b;
  wire [2:0] sel_a, sel_b;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int fac [12] = '{1024, 1149, 1289, 1446, 1623, 1821, 2043, 2292, 2572,
    2886, 3238, 3633};
  logic pen [2] = '{1'b0, 1'b0};
  logic aen [2] = '{1'b0, 1'b0};
  logic [2:0] psel [2] = '{3'h0, 3'h0};
  logic [2:0] asel [2] = '{3'h0, 3'h0};
  logic [31:0] rv;
  logic [3:0] kb;

  grz_top u_grz_top (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .chan_a_sample_in(in_a),
    .chan_b_sample_in(in_b), .chan_a_sample_out(out_a),
    .chan_b_sample_out(out_b), .core_reset_out(core_rst),
    .chan_a_zone_en(en_a), .chan_a_zone_sel(sel_a),
    .chan_b_zone_en(en_b), .chan_b_zone_sel(sel_b));

  // clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  // ----
  // helpers
  // ----
  task complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    num_checks++;
    if (seen !== ex) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  // one single word transfer, waits on hready in both phases
  task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask

  task rd(input string nm, input logic [7:0] idx, input logic [31:0] ex);
    xfer(1'b0, idx, 32'h0);
    chk(nm, rv, ex);
  endtask

  task page(input logic [23:0] p);
    wr(`GRZ_IDX_PAGE, {8'h0, p});
  endtask

  // expected gained and saturated sample
  function logic [31:0] gexp(input logic [13:0] x, input int k);
    int p;
    p = ($signed(x) * ((k > 11) ? 1024 : fac[k])) >>> 10;
    if (p > 8191) p = 8191;
    if (p < -8192) p = -8192;
    return {18'h0, p[13:0]};
  endfunction

  task zw(input int c, input logic [7:0] v);
    page(c ? `GRZ_PAGE_MAIN_B : `GRZ_PAGE_MAIN_A);
    wr(`GRZ_IDX_ZONE, {24'h0, 4'h0, v[3], psel[c]});
    wr(`GRZ_IDX_ZONE, {24'h0, v});
    pen[c] = v[3];
    psel[c] = v[2:0];
  endtask

  // core reset pulse from one page, model activates pending zones
  task pulse(input int c);
    page(c ? `GRZ_PAGE_MAIN_B : `GRZ_PAGE_MAIN_A);
    wr(`GRZ_IDX_CORE_RESET, 32'h1);
    @(posedge clk);
    #1;
    chk("core_rst", core_rst, 1);
    chk("out_a_clr", out_a, 0);
    wr(`GRZ_IDX_CORE_RESET, 32'h0);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      aen[i] = pen[i];
      if (!psel[i][2]) asel[i] = psel[i];
    end
  endtask

  task zcheck;
    #1;
    chk("en_a", en_a, aen[0]);
    chk("sel_a", sel_a, asel[0]);
    chk("en_b", en_b, aen[1]);
    chk("sel_b", sel_b, asel[1]);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'h5c310de2));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    zcheck();
    rd("page_rst", `GRZ_IDX_PAGE, 0);
    for (int k = 0; k < 16; k++) begin
      kb = 4'hf - k[3:0];
      page(`GRZ_PAGE_GAIN_A);
      wr(`GRZ_IDX_GAIN, {24'h0, 4'hf, k[3:0]});
      rd("gain_a", `GRZ_IDX_GAIN, k);
      page(`GRZ_PAGE_GAIN_B);
      wr(`GRZ_IDX_GAIN, {28'h0, kb});
      @(posedge clk);
      in_a <= 14'($urandom);
      in_b <= 14'($urandom);
      @(posedge clk);
      #1;
      chk("out_a", out_a, gexp(in_a, k));
      chk("out_b", out_b, gexp(in_b, kb));
    end
    page(`GRZ_PAGE_MAIN_A);
    rd("zone_rst", `GRZ_IDX_ZONE, 0);
    zw(0, 8'h0a);
    zw(1, 8'h0b);
    zcheck();
    pulse(1);
    zcheck();
    zw(1, 8'h0e);
    rd("zone_b_rsvd", `GRZ_IDX_ZONE, 32'h0e);
    zw(0, 8'h01);
    pulse(0);
    zcheck();
    rd("status", `GRZ_IDX_STATUS, {23'h0, asel[1], aen[1], asel[0],
      aen[0], 1'b0});
    rd("unmapped", 8'h10, 0);
    page(`GRZ_PAGE_MAIN_A);
    wr(`GRZ_IDX_CORE_RESET, 32'hfe);
    rd("rst_bits", `GRZ_IDX_CORE_RESET, 0);
    page(`GRZ_PAGE_GAIN_A);
    rd("mismatch", `GRZ_IDX_ZONE, 0);
    complete_run();
  end
endmodule

bind grz_top grz_top_asserts u_grz_top_asserts (.clk(clk), .resetn(resetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp),
  .chan_a_sample_out(chan_a_sample_out),
  .chan_b_sample_out(chan_b_sample_out), .core_reset_out(core_reset_out),
  .chan_a_zone_en(chan_a_zone_en), .chan_a_zone_sel(chan_a_zone_sel),
  .chan_b_zone_en(chan_b_zone_en), .chan_b_zone_sel(chan_b_zone_sel));
